// ==== verilog/pulse_measure_generate_pkg.sv ====
`default_nettype none
package pulse_measure_generate_pkg;

  // ===========================================================================
  // Register map, byte addresses on a 32-bit classic Wishbone bus.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_OPERAND  = 8'h04;
  localparam logic [7:0] ADDR_LIMIT    = 8'h08;
  localparam logic [7:0] ADDR_RESULT   = 8'h0c;
  localparam logic [7:0] ADDR_RES_BYTE = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_RANDOM   = 8'h18;

  // ===========================================================================
  // Field positions.
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_PIN_LSB  = 8;
  localparam int CTRL_GO_BIT   = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int OPND_CNT_LSB  = 16;

  // ===========================================================================
  // Operation codes written to the control register.
  localparam logic [2:0] OP_WIDTH  = 3'h0;
  localparam logic [2:0] OP_STATE  = 3'h1;
  localparam logic [2:0] OP_PULSE  = 3'h2;
  localparam logic [2:0] OP_PWM    = 3'h3;
  localparam logic [2:0] OP_RANDOM = 3'h4;

  // ===========================================================================
  // Reset values, generator taps and full-duty code.
  localparam logic [15:0] LIMIT_RESET  = 16'hffff;
  localparam logic [15:0] RANDOM_RESET = 16'h0001;
  localparam logic [15:0] LFSR_TAPS    = 16'hb400;
  localparam logic [7:0]  DUTY_FULL    = 8'hff;

  // ===========================================================================
  // Timing. Counts are fixed numbers of oscillator cycles, so the real-time
  // resolution follows whatever clock actually runs.
  localparam int REF_OSC_KHZ      = 4000;
  localparam int UNIT_REF_NS      = 10000;
  localparam int PWM_CYCLE_REF_US = 5000;
  localparam int PWM_STEPS        = 256;
  localparam int UNIT_CYCLES      = UNIT_REF_NS * REF_OSC_KHZ / 1000000;
  localparam int PWM_STEP_CYCLES  = PWM_CYCLE_REF_US * REF_OSC_KHZ / 1000 / PWM_STEPS;
  localparam logic [6:0] UNIT_LAST = 7'(UNIT_CYCLES - 1);
  localparam logic [6:0] STEP_LAST = 7'(PWM_STEP_CYCLES - 1);

endpackage : pulse_measure_generate_pkg
`default_nettype wire

// ==== verilog/pulse_measure_generate.sv ====
// Register access over Wishbone and the register addresses are this design's own decisions.
`default_nettype none
// Overview of operation
// - Width measurement times a low pulse for polarity zero, high for one.
// - Missing edge or overlong pulse yields a measured width of zero.
// - Width is kept in 16 bits; the byte view returns the low byte.
// - Width measurement makes the selected pin an input on start.
// - Measurement counts once per 40 oscillator cycles, scaling with clock.
// - Resolution follows the running clock; no frequency setting alters it.
// - Waiting gives up after the count limit, default 65535, for both measurements.
// - Single pulse toggles the pin twice; prior level sets polarity.
// - Single pulse drives the selected pin as an output first.
// - Pulse length equals period times a 40-cycle unit, plus one cycle.
// - Modulation cycle has 256 steps; duty 0 never high, 255 always.
// - Modulation cycle repeats exactly the requested count then stops.
// - One modulation cycle lasts about 20000 oscillator cycles.
// - Pin is output during modulation and returns to input afterwards.
// - Random step updates 16-bit value in place; period 65535, never zero.
// - State duration counts time at the level immediately, no leading edge.
// - State duration reaching the limit returns zero.
// - State duration uses the same 40-cycle unit as width measurement.
module pulse_measure_generate
  import pulse_measure_generate_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic [15:0] i_pin,
  output logic      [15:0] o_pin_out,
  output logic      [15:0] o_pin_oe,
  output logic             o_done
);

  typedef enum logic [2:0] {IDLE, ARM_QUIET, ARM_EDGE, RUN, PULSE, PWM} state_e;

  // ===========================================================================
  // Reset release and pin synchronisers.
  logic        rst_q1;
  logic        rst_n;
  logic [15:0] pin_q1;
  logic [15:0] pin_s;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= 16'h0000;
      pin_s  <= 16'h0000;
    end else begin
      pin_q1 <= i_pin;
      pin_s  <= pin_q1;
    end
  end

  // ===========================================================================
  // Wishbone slave decode. Every access is acknowledged one cycle after the
  // request. A write lands at the edge that samples ack high, the same edge at
  // which the master sees it; unmapped addresses read zero and ignore writes.
  logic        ack;
  logic [2:0]  op;
  logic        pol;
  logic [3:0]  pin_sel;
  logic [15:0] operand_a;
  logic [15:0] operand_b;
  logic [15:0] limit;
  logic [15:0] result;
  logic [15:0] rnd;
  logic        done_flag;
  state_e      state;

  wire req       = i_wb_cyc && i_wb_stb && !ack;
  wire wr        = i_wb_cyc && i_wb_stb && ack && i_wb_we;
  wire wr_ctrl   = wr && (i_wb_adr == ADDR_CTRL);
  wire wr_opnd   = wr && (i_wb_adr == ADDR_OPERAND);
  wire wr_limit  = wr && (i_wb_adr == ADDR_LIMIT);
  wire wr_status = wr && (i_wb_adr == ADDR_STATUS);
  wire wr_random = wr && (i_wb_adr == ADDR_RANDOM);
  wire busy      = (state != IDLE);
  wire start     = wr_ctrl && i_wb_sel[2] && i_wb_dat[CTRL_GO_BIT] && !busy;

  wire [31:0] rd_ctrl   = {16'h0000, 4'h0, pin_sel, 3'h0, pol, 1'b0, op};
  wire [31:0] rd_status = {30'h0, done_flag, busy};
  wire [31:0] rd_mux =
      (i_wb_adr == ADDR_CTRL)     ? rd_ctrl :
      (i_wb_adr == ADDR_OPERAND)  ? {operand_b, operand_a} :
      (i_wb_adr == ADDR_LIMIT)    ? {16'h0000, limit} :
      (i_wb_adr == ADDR_RESULT)   ? {16'h0000, result} :
      (i_wb_adr == ADDR_RES_BYTE) ? {24'h000000, result[7:0]} :
      (i_wb_adr == ADDR_STATUS)   ? rd_status :
      (i_wb_adr == ADDR_RANDOM)   ? {16'h0000, rnd} : 32'h00000000;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      ack      <= req;
      o_wb_dat <= req ? rd_mux : 32'h00000000;
    end
  end
  assign o_wb_ack = ack;

  // Configuration is frozen while an operation runs so it cannot change midway.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op        <= OP_WIDTH;
      pol       <= 1'b0;
      pin_sel   <= 4'h0;
      operand_a <= 16'h0000;
      operand_b <= 16'h0000;
      limit     <= LIMIT_RESET;
    end else if (!busy) begin
      if (wr_ctrl && i_wb_sel[0]) begin
        op  <= i_wb_dat[CTRL_OP_LSB +: 3];
        pol <= i_wb_dat[CTRL_POL_BIT];
      end
      if (wr_ctrl && i_wb_sel[1]) begin
        pin_sel <= i_wb_dat[CTRL_PIN_LSB +: 4];
      end
      if (wr_opnd && i_wb_sel[0]) begin
        operand_a <= i_wb_dat[15:0];
      end
      if (wr_opnd && i_wb_sel[2]) begin
        operand_b <= i_wb_dat[OPND_CNT_LSB +: 16];
      end
      if (wr_limit && i_wb_sel[0]) begin
        limit <= i_wb_dat[15:0];
      end
    end
  end

  // ===========================================================================
  // Timebase. One fixed prescaler; no frequency setting feeds it.
  logic [6:0]  pre;
  logic [15:0] cnt;
  logic [7:0]  step;
  logic        start_level;

  wire [6:0] pre_last = (state == PWM) ? STEP_LAST : UNIT_LAST;
  wire       tick     = busy && (pre == pre_last);
  wire       pin_now  = pin_s[pin_sel];
  wire       at_level = (pin_now == pol);
  wire       at_limit = (cnt == limit);
  wire [7:0] duty     = operand_a[7:0];
  wire       pwm_high = (duty == DUTY_FULL) || (step < duty);
  wire [15:0] lfsr_nx = rnd[0] ? ((rnd >> 1) ^ LFSR_TAPS) : (rnd >> 1);
  wire       meas     = (state == ARM_QUIET) || (state == ARM_EDGE) || (state == RUN);
  wire       timeout  = meas && tick && at_limit && !(state == RUN && !at_level);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 7'h00;
    end else if (!busy || tick) begin
      pre <= 7'h00;
    end else begin
      pre <= pre + 7'h01;
    end
  end

  // ===========================================================================
  // Operation sequencer.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state       <= IDLE;
      cnt         <= 16'h0000;
      step        <= 8'h00;
      result      <= 16'h0000;
      rnd         <= RANDOM_RESET;
      o_pin_out   <= 16'h0000;
      o_pin_oe    <= 16'h0000;
      o_done      <= 1'b0;
      start_level <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (wr_random && i_wb_sel[0] && !busy) begin
        // A zero seed would lock the generator, so it is replaced.
        rnd <= (i_wb_dat[15:0] == 16'h0000) ? RANDOM_RESET : i_wb_dat[15:0];
      end
      unique case (state)
        IDLE: begin
          cnt  <= 16'h0000;
          step <= 8'h00;
          if (start) begin
            unique case (op)
              OP_WIDTH: begin
                o_pin_oe[pin_sel] <= 1'b0;
                state <= ARM_QUIET;
              end
              OP_STATE: begin
                o_pin_oe[pin_sel] <= 1'b0;
                state <= RUN;
              end
              OP_PULSE: begin
                o_pin_oe[pin_sel]  <= 1'b1;
                o_pin_out[pin_sel] <= !o_pin_out[pin_sel];
                start_level        <= o_pin_out[pin_sel];
                state <= PULSE;
              end
              OP_PWM: begin
                if (operand_b == 16'h0000) begin
                  o_done <= 1'b1;
                end else begin
                  o_pin_oe[pin_sel] <= 1'b1;
                  state <= PWM;
                end
              end
              default: begin
                rnd    <= lfsr_nx;
                result <= lfsr_nx;
                o_done <= 1'b1;
              end
            endcase
          end
        end
        ARM_QUIET: begin
          // Wait for the inactive level so a pulse already in progress is skipped.
          if (timeout) begin
            result <= 16'h0000;
            o_done <= 1'b1;
            state  <= IDLE;
          end else begin
            if (tick) begin
              cnt <= cnt + 16'h0001;
            end
            if (!at_level) begin
              state <= ARM_EDGE;
            end
          end
        end
        ARM_EDGE: begin
          if (timeout) begin
            result <= 16'h0000;
            o_done <= 1'b1;
            state  <= IDLE;
          end else if (at_level) begin
            cnt   <= 16'h0000;
            state <= RUN;
          end else if (tick) begin
            cnt <= cnt + 16'h0001;
          end
        end
        RUN: begin
          if (!at_level) begin
            result <= cnt;
            o_done <= 1'b1;
            state  <= IDLE;
          end else if (timeout) begin
            result <= 16'h0000;
            o_done <= 1'b1;
            state  <= IDLE;
          end else if (tick) begin
            cnt <= cnt + 16'h0001;
          end
        end
        PULSE: begin
          if (cnt == operand_a) begin
            o_pin_out[pin_sel] <= start_level;
            o_done <= 1'b1;
            state  <= IDLE;
          end else if (tick) begin
            cnt <= cnt + 16'h0001;
          end
        end
        PWM: begin
          o_pin_out[pin_sel] <= pwm_high;
          if (tick) begin
            step <= step + 8'h01;
            if (step == DUTY_FULL) begin
              if (cnt + 16'h0001 == operand_b) begin
                o_pin_oe[pin_sel] <= 1'b0;
                o_done <= 1'b1;
                state  <= IDLE;
              end else begin
                cnt <= cnt + 16'h0001;
              end
            end
          end
        end
      endcase
    end
  end

  // ===========================================================================
  // Done flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (o_done) begin
      done_flag <= 1'b1;
    end else if (wr_status && i_wb_sel[0] && i_wb_dat[STAT_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // ===========================================================================
  // Checks.
  a_done_single: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    o_done |=> !o_done)
    else $error("done strobe lasted more than one cycle");

  a_measure_input: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    meas |-> !o_pin_oe[pin_sel])
    else $error("pin driven during measurement");

  a_pulse_output: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PULSE) |-> o_pin_oe[pin_sel] && (o_pin_out[pin_sel] != start_level))
    else $error("single pulse not driven at toggled level");

  a_pulse_restores: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PULSE) ##1 (state == IDLE) |-> o_done && (o_pin_out[pin_sel] == start_level))
    else $error("single pulse did not toggle back");

  a_timeout_zero: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    timeout |=> o_done && (result == 16'h0000) && (state == IDLE))
    else $error("timeout did not return zero");

  a_unit_spacing: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (tick && meas) |=> !tick [*8])
    else $error("measurement unit shorter than expected");

  a_pwm_full: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PWM && duty == DUTY_FULL) |=> o_pin_out[pin_sel] || (state != PWM))
    else $error("full duty output went low");

  a_pwm_zero: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PWM && duty == 8'h00) |=> !o_pin_out[pin_sel])
    else $error("zero duty output went high");

  a_pwm_release: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PWM) ##1 (state == IDLE) |-> !o_pin_oe[pin_sel] && o_done)
    else $error("pin not returned to input after modulation");

  a_pwm_drive: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PWM) |-> o_pin_oe[pin_sel])
    else $error("pin not driven during modulation");

  a_start_answer: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    start |=> busy || o_done)
    else $error("start neither ran nor finished");

  a_random_nonzero: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    rnd != 16'h0000)
    else $error("random value reached zero");

  a_bus_ack: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus acknowledge timing wrong");

  c_width_done: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == RUN) ##1 (o_done && result != 16'h0000));
  c_timeout: cover property (@(posedge i_clk_sys) disable iff (!rst_n) timeout);
  c_pwm_done: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PWM) ##1 o_done);
  c_pulse_done: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    (state == PULSE) ##1 o_done);

endmodule : pulse_measure_generate
`default_nettype wire

// ==== test/pulse_source_model.sv ====
`default_nettype none
module pulse_source_model #(
  parameter int RC_PIN    = 3,
  parameter int RC_CYCLES = 2000
) (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_level,
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  output logic      [15:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // RC node
  // Driving the node low empties the capacitor; once released it charges
  // through the resistor and crosses the input threshold after RC_CYCLES.
  int charge = 0;

  always @(posedge i_clk) begin
    if (i_pin_oe[RC_PIN] && !i_pin_out[RC_PIN]) begin
      charge <= 0;
    end else if (charge < RC_CYCLES) begin
      charge <= charge + 1;
    end
  end

  // ==========================================================================
  // Pin levels
  // A pin the device drives shows its drive level, otherwise the source level, or the RC node level for RC_PIN.
  always_comb begin
    o_pin = i_level;
    o_pin[RC_PIN] = (charge >= RC_CYCLES);
    for (int i = 0; i < 16; i++) begin
      if (i_pin_oe[i]) begin
        o_pin[i] = i_pin_out[i];
      end
    end
  end
endmodule : pulse_source_model
`default_nettype wire

// ==== test/pulse_measure_generate_test.sv ====
`default_nettype none
module pulse_measure_generate_test import pulse_measure_generate_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys, resetn, wb_cyc, wb_stb, wb_we, ack, done, mon_clr;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd, rb;
  logic [15:0] pin_in, pin_out, pin_oe, src_level, lfsr;
  int          miscompares, comparisons, k, mon_pin, done_base;
  int          oe_cyc = 0, hi_cyc = 0, done_cnt = 0;
  int          wid[2] = '{260, 20};
  int          per[2] = '{3, 0};
  int          pw_pin[4] = '{5, 5, 5, 3};
  int          pw_duty[4] = '{64, 255, 0, 0};
  int          pw_cnt[4] = '{2, 1, 0, 1};

  pulse_measure_generate pulse_measure_generate_inst (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
    .o_wb_dat(wb_rdat), .o_wb_ack(ack), .i_pin(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_done(done));

  pulse_source_model pulse_source_model_inst (
    .i_clk(clk_sys), .i_level(src_level), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .o_pin(pin_in));

  // ==========================================================================
  // Clock, watchdog and pin monitor
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    #(64'd110_000 * 100);
    miscompares++;
    finish_test();
  end

  always @(posedge clk_sys) begin
    if (mon_clr) begin
      oe_cyc <= 0;
      hi_cyc <= 0;
    end else begin
      oe_cyc <= oe_cyc + int'(pin_oe[mon_pin]);
      hi_cyc <= hi_cyc + int'(pin_oe[mon_pin] & pin_out[mon_pin]);
    end
    done_cnt <= done_cnt + int'(done);
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] near(input logic [31:0] got, input int exp, input int tol);
    return 32'(got - 32'(exp) + 32'(tol) <= 32'(2 * tol));
  endfunction : near

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] q);
    int n;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    wb_sel  <= sel;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("wb_ack", {31'h0, ack}, 32'h1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] q;
    wb_xfer(1'b1, adr, dat, sel, q);
  endtask : wr

  task automatic rdreg(input logic [7:0] adr, output logic [31:0] q);
    wb_xfer(1'b0, adr, 32'h0, 4'hf, q);
  endtask : rdreg

  // Configuration goes in a write of its own, since go uses the stored setup.
  task automatic run_op(input logic [2:0] op, input logic pol, input logic [3:0] pin,
                        input logic [31:0] opnd);
    wr(ADDR_OPERAND, opnd, 4'hf);
    wr(ADDR_CTRL, {20'h0, pin, 3'h0, pol, 1'b0, op}, 4'h3);
    mon_pin = int'(pin);
    done_base = done_cnt;
    mon_clr <= 1'b1;
    @(posedge clk_sys);
    mon_clr <= 1'b0;
    wr(ADDR_CTRL, 32'h0001_0000, 4'h4);
  endtask : run_op

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rdreg(ADDR_STATUS, rd);
      n++;
    end while (rd[STAT_DONE_BIT] !== 1'b1 && n < 30000);
    check("done_flag", {31'h0, rd[STAT_DONE_BIT]}, 32'h1);
    check("done_pulses", 32'(done_cnt), 32'(done_base + 1));
    wr(ADDR_STATUS, 32'h2, 4'h1);
  endtask : wait_done

  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Test sequence
  initial begin
    resetn = 1'b0;
    {wb_cyc, wb_stb, wb_we, mon_clr} = 4'h0;
    wb_adr = 8'h0;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    src_level = 16'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("oe_reset", 32'(pin_oe), 32'h0);
    rdreg(ADDR_LIMIT, rd);
    check("limit_reset", rd, {16'h0, LIMIT_RESET});
    rdreg(8'h1c, rd);
    check("unmapped", rd, 32'h0);
    lfsr = RANDOM_RESET;
    for (k = 0; k < 3; k++) begin
      lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0);
      run_op(OP_RANDOM, 1'b0, 4'h0, 32'h0);
      wait_done();
      rdreg(ADDR_RESULT, rd);
      check("random_step", rd, {16'h0, lfsr});
      rdreg(ADDR_RANDOM, rd);
      check("random_value", rd, {16'h0, lfsr});
    end
    wr(ADDR_RANDOM, 32'h0, 4'h3);
    rdreg(ADDR_RANDOM, rd);
    check("zero_seed", rd, 32'h1);
    for (k = 0; k < 2; k++) begin
      run_op(OP_PULSE, 1'b0, 4'h4, 32'(per[k]));
      wait_done();
      check("pulse_oe", 32'(pin_oe[4]), 32'h1);
      check("pulse_len", near(hi_cyc, per[k] * UNIT_CYCLES + 1, 1), 32'h1);
      check("pulse_back", 32'(pin_out[4]), 32'h0);
    end
    for (k = 0; k < 2; k++) begin
      src_level[4] <= ~k[0];
      run_op(OP_WIDTH, k[0], 4'h4, 32'h0);
      check("width_input", 32'(pin_oe[4]), 32'h0);
      rdreg(ADDR_STATUS, rd);
      check("busy", {31'h0, rd[STAT_BUSY_BIT]}, 32'h1);
      repeat (20) @(posedge clk_sys);
      src_level[4] <= k[0];
      repeat (wid[k] * UNIT_CYCLES) @(posedge clk_sys);
      src_level[4] <= ~k[0];
      wait_done();
      rdreg(ADDR_RESULT, rd);
      check("width_count", near(rd, wid[k], 1), 32'h1);
      rdreg(ADDR_RES_BYTE, rb);
      check("width_byte", rb, {24'h0, rd[7:0]});
    end
    wr(ADDR_LIMIT, 32'h5, 4'h3);
    src_level[6] <= 1'b0;
    for (k = 0; k < 2; k++) begin
      run_op(k ? OP_STATE : OP_WIDTH, ~k[0], 4'h6, 32'h0);
      wait_done();
      rdreg(ADDR_RESULT, rd);
      check("timeout_zero", rd, 32'h0);
    end
    wr(ADDR_LIMIT, 32'hffff, 4'h3);
    for (k = 0; k < 4; k++) begin
      run_op(OP_PWM, 1'b0, 4'(pw_pin[k]), {16'(pw_cnt[k]), 16'(pw_duty[k])});
      wait_done();
      check("pwm_span", near(oe_cyc, pw_cnt[k] * PWM_STEPS * PWM_STEP_CYCLES, 2),
            32'h1);
      check("pwm_high", near(hi_cyc, pw_cnt[k] * (pw_duty[k] == 255 ? PWM_STEPS : pw_duty[k])
                                    * PWM_STEP_CYCLES, 2), 32'h1);
      check("pwm_release", 32'(pin_oe[pw_pin[k]]), 32'h0);
    end
    run_op(OP_STATE, 1'b0, 4'h3, 32'h0);
    wait_done();
    rdreg(ADDR_RESULT, rd);
    check("state_count", near(rd, 2000 / UNIT_CYCLES - 2, 2), 32'h1);
    finish_test();
  end
endmodule : pulse_measure_generate_test
`default_nettype wire
